// File: core/dpi2_pkg.sv
// package: constants and types shared by both ends of the potentiometer serial port
// Summary of operation
// - master starts transfers and drives clock
// - bytes shift most significant bit first
// - data changes only while clock low
// - target data pin undriven after power-up
// - target acts only after a start
// - start ignored during power-up quiet period
// - stop ends operation, target to standby
// - transmitter releases, receiver acks ninth clock
// - target acks identification and address bytes
// - target acks the one written data byte, then idles
// - master acks read bytes except last
// - identification 10100 plus two strap levels
// - identification lsb one reads, zero writes
// - write is id, address, data, stop
// - write data lands at ninth clock
// - read uses repeated start and read id
// - target sends bytes while master acknowledges
// - master ends read with nack, stop
// - master waits 50ms before first access
// - wiper register address 0, reset 40h
// - access control 10h, bit6 shutdown_n
// - shutdown keeps wiper register contents
package dpi2_pkg;
  localparam logic [4:0] ID_FIXED = 5'h14;
  localparam logic [7:0] WIPER_ADDR = 8'h00;
  localparam logic [7:0] ACCESS_ADDR = 8'h10;
  localparam logic [6:0] WIPER_RESET = 7'h40;
  localparam int SHUTDOWN_BIT = 6;
  localparam logic SHUTDOWN_N_RESET = 1'b1;
  localparam int CLK_MHZ = 50;
  localparam int LINK_HALF_NS = 80;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int POWERUP_US = 100;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int HOST_WAIT_MS = 50;
  localparam int HOST_WAIT_CYC = HOST_WAIT_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    DPI2_CMD_WRITE,
    DPI2_CMD_READ
  } dpi2_cmd_type;
endpackage : dpi2_pkg

// File: core/dpi2_link_if.sv
// interface: the two-wire link between master and potentiometer target
`timescale 1ns/1ps
interface dpi2_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // open-drain wires: pulled up unless a driver pulls low
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
  modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
    input scl, input sda);
  modport device (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface : dpi2_link_if

// File: core/dpi2_target.sv
// module: potentiometer target end of the two-wire link with its two registers
`timescale 1ns/1ps
module dpi2_target
  import dpi2_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  dpi2_link_if.device link,
  input wire logic addr_strap_lo,
  input wire logic addr_strap_hi,
  output logic [6:0] wiper,
  output logic shutdown_n,
  output logic busy
);
  import dpi2_pkg::*;

  if (POWERUP_CYCLES < 1) begin : g_bad_powerup
    $error("POWERUP_CYCLES must be at least 1");
  end

  // ****************************************
  // synchronisers
  // ****************************************
  logic [1:0] scl_s_q, sda_s_q, strap_s_q;
  logic [1:0] strap_lo_s_q;
  logic scl_q, sda_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      strap_s_q <= 2'h0;
      strap_lo_s_q <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      strap_s_q <= {strap_s_q[0], addr_strap_hi};
      strap_lo_s_q <= {strap_lo_s_q[0], addr_strap_lo};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  end
  logic scl_w, sda_w;
  assign scl_w = scl_s_q[1];
  assign sda_w = sda_s_q[1];
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_w && !scl_q;
  assign scl_fall = !scl_w && scl_q;
  assign start_ev = scl_w && scl_q && sda_q && !sda_w;
  assign stop_ev = scl_w && scl_q && !sda_q && sda_w;

  // ****************************************
  // power-up quiet period
  // ****************************************
  logic [$clog2(POWERUP_CYCLES+1)-1:0] pwr_cnt_q;
  logic ready;
  assign ready = (pwr_cnt_q == '0);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_q <= ($clog2(POWERUP_CYCLES+1))'(POWERUP_CYCLES);
    end else if (clk_en && !ready) begin
      pwr_cnt_q <= pwr_cnt_q - 1'b1;
    end
  end

  // ****************************************
  // byte engine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK
  } dpi2_state_type;
  typedef enum logic [1:0] {
    PH_ID, PH_ADDR, PH_DATA
  } dpi2_phase_type;
  dpi2_state_type st_q;
  dpi2_phase_type ph_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] reg_addr_q;
  logic addr_ok_q;
  logic sda_drv_q;
  logic ack_rose_q;

  function automatic logic id_match(input logic [7:0] b, input logic hi, input logic lo);
    return b[7:3] == ID_FIXED && b[2] == hi && b[1] == lo;
  endfunction : id_match

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [6:0] w,
    input logic s);
    if (a == WIPER_ADDR) return {1'b0, w};
    if (a == ACCESS_ADDR) return 8'h00 | (8'(s) << SHUTDOWN_BIT);
    return 8'h00;
  endfunction : reg_read

  // one read mux for both load points; a function result cannot be bit-selected
  logic [7:0] rd_byte;
  assign rd_byte = reg_read(reg_addr_q, wiper, shutdown_n);

  logic [7:0] rx_byte;
  assign rx_byte = sh_q;
  logic do_write;
  assign do_write = (st_q == ST_ACK) && (ph_q == PH_DATA) && scl_rise;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      ph_q <= PH_ID;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      reg_addr_q <= 8'h00;
      addr_ok_q <= 1'b0;
      sda_drv_q <= 1'b0;
      ack_rose_q <= 1'b0;
    end else if (clk_en) begin
      if (stop_ev) begin
        st_q <= ST_IDLE;
        sda_drv_q <= 1'b0;
      end else if (start_ev && ready) begin
        st_q <= ST_RECV;
        ph_q <= PH_ID;
        bit_q <= 4'h0;
        sda_drv_q <= 1'b0;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            sda_drv_q <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_w};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              ack_rose_q <= 1'b0;
              if (ph_q == PH_ID && !id_match(rx_byte, strap_s_q[1], strap_lo_s_q[1])) begin
                st_q <= ST_IDLE;
              end else begin
                st_q <= ST_ACK;
                sda_drv_q <= 1'b1;
                if (ph_q == PH_ADDR) reg_addr_q <= rx_byte;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise) ack_rose_q <= 1'b1;
            if (scl_fall && ack_rose_q) begin
              ack_rose_q <= 1'b0;
              sda_drv_q <= 1'b0;
              unique case (ph_q)
                PH_ID: begin
                  if (rx_byte[0]) begin
                    st_q <= ST_SEND;
                    sh_q <= rd_byte;
                    sda_drv_q <= !rd_byte[7];
                    bit_q <= 4'h1;
                  end else begin
                    st_q <= ST_RECV;
                    ph_q <= PH_ADDR;
                  end
                end
                PH_ADDR: begin
                  st_q <= ST_RECV;
                  ph_q <= PH_DATA;
                end
                default: st_q <= ST_IDLE;
              endcase
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                st_q <= ST_MACK;
                sda_drv_q <= 1'b0;
                bit_q <= 4'h0;
              end else begin
                sda_drv_q <= !sh_q[3'(7 - bit_q)];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) ack_rose_q <= !sda_w;
            if (scl_fall) begin
              if (ack_rose_q) begin
                st_q <= ST_SEND;
                sh_q <= rd_byte;
                sda_drv_q <= !rd_byte[7];
                bit_q <= 4'h1;
              end else begin
                st_q <= ST_IDLE;
              end
              ack_rose_q <= 1'b0;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper <= WIPER_RESET;
      shutdown_n <= SHUTDOWN_N_RESET;
    end else if (clk_en && do_write) begin
      // shutdown only gates the analog side; wiper value is kept
      if (reg_addr_q == WIPER_ADDR) wiper <= sh_q[6:0];
      if (reg_addr_q == ACCESS_ADDR) shutdown_n <= sh_q[SHUTDOWN_BIT];
    end
  end

  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = sda_drv_q;
  assign busy = (st_q != ST_IDLE);
endmodule : dpi2_target

// File: core/dpi2_master.sv
// module: two-wire master end that issues register writes and reads
`timescale 1ns/1ps
module dpi2_master
  import dpi2_pkg::*;
#(
  parameter int WAIT_CYCLES = HOST_WAIT_CYC,
  parameter int HALF_CYCLES = LINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  dpi2_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire dpi2_pkg::dpi2_cmd_type req_cmd,
  input wire logic [1:0] req_strap,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic [7:0] req_count,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import dpi2_pkg::*;

  if (HALF_CYCLES < 2) begin : g_bad_half
    $error("HALF_CYCLES must be at least 2");
  end
  if (WAIT_CYCLES < 1) begin : g_bad_wait
    $error("WAIT_CYCLES must be at least 1");
  end

  // ****************************************
  // start-up wait and clock divider
  // ****************************************
  logic [$clog2(WAIT_CYCLES+1)-1:0] wait_q;
  logic [$clog2(HALF_CYCLES+1)-1:0] div_q;
  logic tick;
  assign tick = (div_q == '0);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= ($clog2(WAIT_CYCLES+1))'(WAIT_CYCLES);
      div_q <= '0;
    end else if (clk_en) begin
      if (wait_q != '0) wait_q <= wait_q - 1'b1;
      div_q <= tick ? ($clog2(HALF_CYCLES+1))'(HALF_CYCLES - 1) : div_q - 1'b1;
    end
  end

  logic [1:0] sda_s_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sda_s_q <= 2'h3;
    else if (clk_en) sda_s_q <= {sda_s_q[0], link.sda};
  end

  // ****************************************
  // sequencer: each step is four ticks (quarter phases)
  // ****************************************
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BYTE, M_RBYTE, M_STOP
  } dpi2_mstate_type;
  dpi2_mstate_type st_q;
  logic [1:0] q_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [7:0] rx_q;
  logic [2:0] idx_q;
  logic [7:0] left_q;
  logic scl_q, sda_q, err_q, is_rd_q;
  logic [7:0] addr_q, data_q;
  logic [1:0] strap_q;

  function automatic logic [7:0] id_byte(input logic [1:0] s, input logic rd);
    return {ID_FIXED, s, rd};
  endfunction : id_byte

  assign req_ready = (st_q == M_IDLE) && (wait_q == '0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= M_IDLE;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 8'h00;
      idx_q <= 3'h0;
      left_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      err_q <= 1'b0;
      is_rd_q <= 1'b0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      strap_q <= 2'h0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (st_q == M_IDLE) begin
        if (req_valid && req_ready) begin
          is_rd_q <= (req_cmd == DPI2_CMD_READ);
          addr_q <= req_addr;
          data_q <= req_data;
          strap_q <= req_strap;
          left_q <= (req_count == 8'h00) ? 8'h01 : req_count;
          idx_q <= 3'h0;
          err_q <= 1'b0;
          q_q <= 2'h0;
          st_q <= M_START;
        end
      end else if (tick) begin
        q_q <= q_q + 2'h1;
        unique case (st_q)
          M_START: begin
            // sda high, scl high, sda low, scl low: also a repeated start
            unique case (q_q)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              2'h3: begin
                scl_q <= 1'b0;
                st_q <= M_BYTE;
                bit_q <= 4'h0;
                tx_q <= {id_byte(strap_q, idx_q == 3'h2), 1'b1};
              end
            endcase
          end
          M_BYTE, M_RBYTE: begin
            unique case (q_q)
              2'h0: begin
                if (st_q == M_RBYTE) begin
                  sda_q <= (bit_q == 4'h8) ? (left_q == 8'h01) : 1'b1;
                end else begin
                  sda_q <= tx_q[8];
                end
              end
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (st_q == M_RBYTE && bit_q != 4'h8) rx_q <= {rx_q[6:0], sda_s_q[1]};
                if (st_q == M_BYTE && bit_q == 4'h8 && sda_s_q[1]) err_q <= 1'b1;
              end
              2'h3: begin
                scl_q <= 1'b0;
                tx_q <= {tx_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  bit_q <= 4'h0;
                  if (st_q == M_RBYTE) begin
                    rsp_valid <= 1'b1;
                    rsp_data <= rx_q;
                    left_q <= left_q - 8'h01;
                    if (left_q == 8'h01) st_q <= M_STOP;
                  end else if (err_q || sda_s_q[1]) begin
                    st_q <= M_STOP;
                  end else begin
                    idx_q <= idx_q + 3'h1;
                    unique case (idx_q)
                      3'h0: tx_q <= {addr_q, 1'b1};
                      3'h1: begin
                        if (is_rd_q) st_q <= M_START;
                        else tx_q <= {data_q, 1'b1};
                      end
                      3'h2: begin
                        if (is_rd_q) st_q <= M_RBYTE;
                        else st_q <= M_STOP;
                      end
                      default: st_q <= M_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          M_STOP: begin
            unique case (q_q)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              2'h3: begin
                st_q <= M_IDLE;
                rsp_nack <= err_q;
                if (!is_rd_q || err_q) rsp_valid <= 1'b1;
              end
            endcase
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe = !scl_q;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = !sda_q;
endmodule : dpi2_master

// File: tb/dpi2_link_asserts.sv
// checker: link-level assertions for the potentiometer serial port
`timescale 1ns/1ps
module dpi2_link_asserts #(
  parameter int POWERUP_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  // ******************************
  // bus decoding seen from the wire
  // ******************************
  logic scl_q, sda_q, rd_q, first_q, ok_q, quiet_q;
  logic start, stop, rise, dev_low, host_low;
  logic [3:0] bit_q;
  int pu_q;
  assign dev_low = sda_dev_oe && !sda_dev_o;
  assign host_low = sda_host_oe && !sda_host_o;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign rise = scl && !scl_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pu_q <= 0;
    else if (pu_q < POWERUP_CYCLES) pu_q <= pu_q + 1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) bit_q <= 4'h0;
    else if (start) bit_q <= 4'h0;
    else if (rise) bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
  end
  // direction comes from the id lsb, taken at the eighth rise of the first byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      first_q <= 1'b0;
    end else if (start) begin
      rd_q <= 1'b0;
      first_q <= 1'b1;
    end else if (rise && first_q && bit_q == 4'h7) rd_q <= sda;
    else if (rise && bit_q == 4'h8) first_q <= 1'b0;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ok_q <= 1'b0;
    else if (start && pu_q >= POWERUP_CYCLES) ok_q <= 1'b1;
  end
  // a refused id or the master's final nack leaves the target quiet until a start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) quiet_q <= 1'b0;
    else if (start) quiet_q <= 1'b0;
    else if (rise && bit_q == 4'h8 && sda && (first_q || rd_q)) quiet_q <= 1'b1;
  end
  // ******************************
  // properties
  // ******************************
  sequence s_scl_falls;
    ##[1:40] !scl;
  endsequence
  sequence s_released8;
    !sda_dev_oe [*8];
  endsequence
  AST_NO_DRIVE_EARLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ok_q |-> !sda_dev_oe) else $error("target drove sda before an accepted start");
  AST_DEV_STABLE_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    scl && scl_q |-> $stable(dev_low)) else $error("target changed sda while scl high");
  AST_WR_DEV_SILENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && !rd_q && bit_q < 4'h8 |-> !dev_low) else $error("target drove a received bit");
  AST_RD_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && rd_q && !first_q && bit_q == 4'h8 |-> !dev_low)
    else $error("target held sda in the master ack slot");
  AST_HOST_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && !rd_q && bit_q == 4'h8 |-> !host_low) else $error("master held sda in ack slot");
  AST_ACK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise && dev_low |-> dev_low throughout s_scl_falls)
    else $error("target let go of sda before scl fell");
  AST_STOP_STANDBY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop |=> s_released8) else $error("target drove sda after a stop");
  AST_NACK_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    quiet_q |-> !sda_dev_oe) else $error("target drove sda after a nack");
endmodule : dpi2_link_asserts

// File: tb/pot_i2c_slave_register_port_test.sv
// testbench: both link ends joined, driven through the master request port
`timescale 1ns/1ps
module pot_i2c_slave_register_port_test;
  import dpi2_pkg::*;
  // target quiet time is longer than the master wait, so the first transfer is refused
  localparam int PU = 300;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid, rsp_nack, shutdown_n, busy;
  dpi2_cmd_type req_cmd = DPI2_CMD_WRITE;
  logic [1:0] req_strap = 2'h0;
  logic [1:0] strap = 2'h2;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic [7:0] req_count = 8'h01;
  logic [7:0] rsp_data;
  logic [7:0] id_seen = 8'h00;
  logic [7:0] id_sh = 8'h00;
  logic [6:0] wiper;
  logic [7:0] got [0:3];
  int fails = 0;
  int n_checks = 0;
  int nbit = 9;
  int k;
  dpi2_link_if u_dpi2_link_if ();
  wire scl = u_dpi2_link_if.scl;
  wire sda = u_dpi2_link_if.sda;
  dpi2_master #(.WAIT_CYCLES(20), .HALF_CYCLES(4)) u_dpi2_master (.ref_clk(ref_clk),
    .rst_n(rst_n), .clk_en(1'b1), .link(u_dpi2_link_if.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_strap(req_strap), .req_addr(req_addr),
    .req_data(req_data), .req_count(req_count), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));
  dpi2_target #(.POWERUP_CYCLES(PU)) u_dpi2_target (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(1'b1), .link(u_dpi2_link_if.device), .addr_strap_lo(strap[0]),
    .addr_strap_hi(strap[1]), .wiper(wiper), .shutdown_n(shutdown_n), .busy(busy));
  dpi2_link_asserts #(.POWERUP_CYCLES(PU)) u_dpi2_link_asserts (.ref_clk(ref_clk),
    .rst_n(rst_n), .scl(scl), .sda(sda), .sda_host_o(u_dpi2_link_if.sda_host_o),
    .sda_host_oe(u_dpi2_link_if.sda_host_oe), .sda_dev_o(u_dpi2_link_if.sda_dev_o),
    .sda_dev_oe(u_dpi2_link_if.sda_dev_oe));
  initial forever #10 ref_clk = ~ref_clk;
  // ******************************
  // wire monitor: first byte after every start
  // ******************************
  always @(negedge sda) if (scl) nbit = 0;
  always @(posedge scl) begin
    if (nbit < 8) begin
      id_sh = {id_sh[6:0], sda};
      nbit++;
      if (nbit == 8) id_seen = id_sh;
    end
  end
  // ******************************
  // tasks
  // ******************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic hang();
    fails++;
    complete_run();
  endtask : hang
  // n is the read byte count; a write or a refused transfer answers once
  task automatic xfer(input dpi2_cmd_type cmd, input logic [1:0] st, input logic [7:0] a,
    input logic [7:0] d, input int n);
    int i;
    int c;
    @(negedge ref_clk);
    req_cmd = cmd;
    req_strap = st;
    req_addr = a;
    req_data = d;
    req_count = 8'(n);
    req_valid = 1'b1;
    i = 0;
    // ready is decoded from registers, settled at the falling edge; the next rise takes it
    while (req_ready !== 1'b1) begin
      i++;
      if (i > 3000) hang();
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    i = 0;
    c = 0;
    while (c < n) begin
      @(negedge ref_clk);
      i++;
      if (i > 20000) hang();
      if (rsp_valid === 1'b1) begin
        got[c] = rsp_data;
        c++;
      end
    end
    // a read answers before its stop; wait for the master to be idle again
    i = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      i++;
      if (i > 200) hang();
    end
  endtask : xfer
  // ******************************
  // scenarios
  // ******************************
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    check(8'(req_ready), 8'h00);
    check(8'(wiper), {1'b0, WIPER_RESET});
    check(8'(shutdown_n), 8'h01);
    check(8'(busy), 8'h00);
    check(8'(sda), 8'h01);
    xfer(DPI2_CMD_WRITE, strap, WIPER_ADDR, 8'h11, 1);
    check(8'(rsp_nack), 8'h01);
    check(8'(wiper), 8'h40);
    repeat (PU) @(negedge ref_clk);
    xfer(DPI2_CMD_WRITE, strap, WIPER_ADDR, 8'h5a, 1);
    check(8'(rsp_nack), 8'h00);
    check(8'(wiper), 8'h5a);
    check(id_seen, {ID_FIXED, strap, 1'b0});
    xfer(DPI2_CMD_READ, strap, WIPER_ADDR, 8'h00, 3);
    for (k = 0; k < 3; k++) check(got[k], 8'h5a);
    check(id_seen, {ID_FIXED, strap, 1'b1});
    check(8'(rsp_nack), 8'h00);
    check(8'(busy), 8'h00);
    xfer(DPI2_CMD_WRITE, strap, ACCESS_ADDR, 8'hff, 1);
    check(8'(shutdown_n), 8'h01);
    xfer(DPI2_CMD_READ, strap, ACCESS_ADDR, 8'h00, 1);
    check(got[0], 8'h40);
    xfer(DPI2_CMD_WRITE, strap, ACCESS_ADDR, 8'h00, 1);
    check(8'(shutdown_n), 8'h00);
    check(8'(wiper), 8'h5a);
    xfer(DPI2_CMD_READ, strap, ACCESS_ADDR, 8'h00, 1);
    check(got[0], 8'h00);
    xfer(DPI2_CMD_READ, strap, WIPER_ADDR, 8'h00, 1);
    check(got[0], 8'h5a);
    // unmapped place reads as zero
    xfer(DPI2_CMD_READ, strap, 8'h33, 8'h00, 1);
    check(got[0], 8'h00);
    xfer(DPI2_CMD_WRITE, ~strap, WIPER_ADDR, 8'h22, 1);
    check(8'(rsp_nack), 8'h01);
    check(8'(wiper), 8'h5a);
    // every strap setting, straps given time to pass the synchroniser
    for (k = 0; k < 4; k++) begin
      strap = 2'(k);
      repeat (8) @(negedge ref_clk);
      xfer(DPI2_CMD_WRITE, strap, WIPER_ADDR, 8'(8'h60 + k), 1);
      check(8'(wiper), 8'(8'h60 + k));
      check(id_seen, {ID_FIXED, strap, 1'b0});
    end
    complete_run();
  end
endmodule : pot_i2c_slave_register_port_test
